// file: inc/acg_pkg.sv
// Constants, types and helpers for the access code generator.
// Assumes a single 10 MHz system clock domain; no software registers.
package acg_pkg;

  localparam int ADDR_W = 24;
  localparam int INFO_W = 30;
  localparam int PAR_W  = 34;
  localparam int SYNC_W = 64;
  localparam int CODE_W = 72;

  // Extension bits, written from position 24 upward: 001101 and 110010
  localparam logic [5:0]  BARKER_EXT0 = 6'h2C;
  localparam logic [5:0]  BARKER_EXT1 = 6'h13;
  // DC-free nibbles, position 0 in bit 0: 0101 and 1010
  localparam logic [3:0]  DCFREE0 = 4'hA;
  localparam logic [3:0]  DCFREE1 = 4'h5;
  // Octal 260534236651, top coefficient in bit 34
  localparam logic [34:0] GEN_POLY = 35'h5_8571_3DA9;

  // Overlay as printed; bit 63 of the literal is overlay bit 0
  localparam logic [63:0] OVL_PRINTED  = 64'h3F2A_33DD_69B1_21C1;
  // Shift-register output as printed, first bit out in bit 63
  localparam logic [63:0] LFSR_PRINTED = 64'h8384_8D96_BBCC_54FC;
  localparam logic [5:0]  LFSR_SEED    = 6'h01;
  localparam logic [5:0]  LFSR_LAST    = 6'd62;

  localparam logic [23:0] INQ_FIRST   = 24'h9E_8B00;
  localparam logic [23:0] INQ_LAST    = 24'h9E_8B3F;
  localparam logic [23:0] INQ_GENERAL = 24'h9E_8B33;

  localparam logic [6:0]  DIV_LAST = 7'd29;
  localparam logic [6:0]  SER_LAST = 7'd71;

  typedef enum logic [2:0] {
    ACG_WAIT_OV = 3'b000,
    ACG_IDLE    = 3'b001,
    ACG_DIVIDE  = 3'b010,
    ACG_FINISH  = 3'b011,
    ACG_SERIAL  = 3'b100
  } acg_fsm_e;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              reserved;
    logic              general;
    logic              dedicated;
  } acg_result_s;

  typedef struct packed {
    acg_fsm_e          fsm;
    logic [ADDR_W-1:0] addr;
    logic [INFO_W-1:0] info;
    logic [PAR_W-1:0]  rem;
    logic [6:0]        cnt;
    logic              ser_en;
    logic [CODE_W-1:0] shift;
    acg_result_s       res;
    logic              done;
  } acg_core_s;

  typedef struct packed {
    logic [5:0]  win;
    logic [63:0] vec;
    logic [5:0]  cnt;
    logic        ready;
  } acg_ovl_s;

  function automatic logic [63:0] bit_rev64(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 64; i++) begin
      r[i] = v[63-i];
    end
    return r;
  endfunction

  // Remainder of a 64-bit polynomial divided by the generator
  function automatic logic [PAR_W-1:0] poly_mod64(input logic [63:0] v);
    logic [PAR_W-1:0] r;
    r = '0;
    for (int i = 63; i >= 0; i--) begin
      r = {r[PAR_W-2:0], v[i]} ^ (r[PAR_W-1] ? GEN_POLY[PAR_W-1:0] : '0);
    end
    return r;
  endfunction

endpackage

// file: rtl/acg_core.sv
// Access code generator: lower address part in, 72-bit access code out.
// Assumes a stable address while start is high; one clock domain.
// Function
// - Info word: address plus six extension bits
// - Extension 001101 or 110010 by address MSB
// - Scramble info with overlay bits 34..63
// - Parity is remainder modulo generator polynomial
// - Codeword parity low, info high, overlay all
// - Overlay equals printed hexadecimal sequence
// - Shift register polynomial gives 63 bits, zero
// - Overlay is register output bit reversed
// - Bit 0 is address LSB
// - Preamble by lowest parity bit, DC-free
// - Sync at 4..67, trailer by address MSB
// - Flag reserved inquiry address range
// - Split general and dedicated inquiry addresses
// - Code is 72 bits from address only
`timescale 1ns/1ps
`default_nettype none
module acg_core (
  // Clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_resetn,
  // Request
  input  wire logic                     i_start,
  input  wire logic [23:0]              i_addr,
  input  wire logic                     i_ser_en,
  // Answer
  output logic                          o_ready,
  output logic                          o_done,
  output acg_pkg::acg_result_s          o_result,
  // Serial code
  output logic                          o_ser_valid,
  output logic                          o_ser_bit
);

  acg_pkg::acg_core_s s_q;
  acg_pkg::acg_core_s s_d;
  logic [63:0]        ovl_seq;
  logic               ovl_ready;
  logic [63:0]        ovl;

  acg_overlay_gen u_ovl (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .o_seq     (ovl_seq),
    .o_ready   (ovl_ready)
  );

  // Position order: ovl[i] is overlay bit i
  assign ovl = acg_pkg::bit_rev64(ovl_seq);

  always_comb begin
    logic        fb;
    logic [4:0]  idx;
    logic [63:0] sync;
    logic        in_rng;
    fb     = 1'b0;
    idx    = '0;
    sync   = '0;
    in_rng = 1'b0;
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.fsm)
      acg_pkg::ACG_WAIT_OV: begin
        // Codes are refused until the overlay is complete
        if (ovl_ready) begin
          s_d.fsm = acg_pkg::ACG_IDLE;
        end
      end
      acg_pkg::ACG_IDLE: begin
        if (i_start) begin
          s_d.addr   = i_addr;
          // Address LSB sits in info bit 0
          s_d.info   = {(i_addr[23] ? acg_pkg::BARKER_EXT1 : acg_pkg::BARKER_EXT0), i_addr};
          s_d.info   = s_d.info ^ ovl[63:34];
          s_d.rem    = '0;
          s_d.cnt    = '0;
          s_d.ser_en = i_ser_en;
          s_d.fsm    = acg_pkg::ACG_DIVIDE;
        end
      end
      acg_pkg::ACG_DIVIDE: begin
        // Bit-serial division, info MSB first: one bit per cycle saves area
        idx     = 5'(acg_pkg::DIV_LAST - s_q.cnt);
        fb      = s_q.info[idx] ^ s_q.rem[acg_pkg::PAR_W-1];
        s_d.rem = {s_q.rem[acg_pkg::PAR_W-2:0], 1'b0} ^ (fb ? acg_pkg::GEN_POLY[acg_pkg::PAR_W-1:0] : '0);
        if (s_q.cnt == acg_pkg::DIV_LAST) begin
          s_d.fsm = acg_pkg::ACG_FINISH;
        end else begin
          s_d.cnt = s_q.cnt + 7'd1;
        end
      end
      acg_pkg::ACG_FINISH: begin
        sync = {s_q.info, s_q.rem} ^ ovl;
        // Preamble keys on parity bit 0 as it stands in the sync word
        s_d.res.code = {(s_q.addr[23] ? acg_pkg::DCFREE1 : acg_pkg::DCFREE0), sync,
                        (sync[0] ? acg_pkg::DCFREE1 : acg_pkg::DCFREE0)};
        in_rng = (s_q.addr >= acg_pkg::INQ_FIRST) && (s_q.addr <= acg_pkg::INQ_LAST);
        s_d.res.reserved  = in_rng;
        s_d.res.general   = (s_q.addr == acg_pkg::INQ_GENERAL);
        s_d.res.dedicated = in_rng && (s_q.addr != acg_pkg::INQ_GENERAL);
        s_d.done  = 1'b1;
        s_d.shift = s_d.res.code;
        s_d.cnt   = '0;
        s_d.fsm   = s_q.ser_en ? acg_pkg::ACG_SERIAL : acg_pkg::ACG_IDLE;
      end
      acg_pkg::ACG_SERIAL: begin
        s_d.shift = {1'b0, s_q.shift[acg_pkg::CODE_W-1:1]};
        if (s_q.cnt == acg_pkg::SER_LAST) begin
          s_d.fsm = acg_pkg::ACG_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 7'd1;
        end
      end
      default: begin
        s_d.fsm = acg_pkg::ACG_WAIT_OV;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{fsm: acg_pkg::ACG_WAIT_OV, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ready     = (s_q.fsm == acg_pkg::ACG_IDLE);
  assign o_done      = s_q.done;
  assign o_result    = s_q.res;
  assign o_ser_valid = (s_q.fsm == acg_pkg::ACG_SERIAL);
  assign o_ser_bit   = s_q.shift[0];

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  logic [6:0] ser_seen_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ser_seen_q <= '0;
    end else if (o_done) begin
      // Bit 0 goes out in the done cycle, so it counts from here
      ser_seen_q <= {6'd0, o_ser_valid};
    end else if (o_ser_valid) begin
      ser_seen_q <= ser_seen_q + 7'd1;
    end
  end

  // Cycles since the taking edge; done elsewhere is a stray pulse
  localparam logic [5:0] DONE_AT = 6'd32;
  logic [5:0] lat_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lat_q <= '0;
    end else if (o_ready && i_start) begin
      lat_q <= 6'd1;
    end else if (o_done) begin
      lat_q <= '0;
    end else if (lat_q != 6'd0) begin
      lat_q <= lat_q + 6'd1;
    end
  end

  AST_INFO_ADDR: assert property (o_done |-> o_result.code[61:38] == s_q.addr)
    else $error("address bits not at sync positions 34..57");

  AST_BARKER: assert property (o_done |->
      o_result.code[67:62] == (s_q.addr[23] ? acg_pkg::BARKER_EXT1 : acg_pkg::BARKER_EXT0))
    else $error("extension bits wrong for address MSB");

  AST_SCRAMBLE: assert property ((s_q.fsm == acg_pkg::ACG_DIVIDE) |->
      s_q.info == ({(s_q.addr[23] ? acg_pkg::BARKER_EXT1 : acg_pkg::BARKER_EXT0), s_q.addr}
                   ^ ovl[63:34]))
    else $error("info word not scrambled by overlay 34..63");

  AST_PARITY: assert property (o_done |->
      acg_pkg::poly_mod64(o_result.code[67:4] ^ ovl) == '0)
    else $error("codeword not a multiple of the generator");

  AST_CODEWORD: assert property ((s_q.fsm == acg_pkg::ACG_FINISH) |=>
      o_result.code[67:4] == ({$past(s_q.info), $past(s_q.rem)} ^ ovl))
    else $error("sync word not codeword xor overlay");

  AST_PREAMBLE: assert property (o_done |->
      o_result.code[3:0] == (o_result.code[4] ? acg_pkg::DCFREE1 : acg_pkg::DCFREE0))
    else $error("preamble does not follow parity bit 0");

  AST_TRAILER: assert property (o_done |->
      o_result.code[71:68] == (s_q.addr[23] ? acg_pkg::DCFREE1 : acg_pkg::DCFREE0))
    else $error("trailer does not follow address MSB");

  AST_RESERVED: assert property (o_done |->
      o_result.reserved == (s_q.addr[23:6] == acg_pkg::INQ_FIRST[23:6]))
    else $error("reserved flag wrong");

  AST_INQ_KIND: assert property (o_done |->
      (o_result.general == (s_q.addr == acg_pkg::INQ_GENERAL)) &&
      (o_result.dedicated == (o_result.reserved && !o_result.general)))
    else $error("inquiry kind flags wrong");

  AST_LATENCY: assert property ((o_ready && i_start) |-> ##32 o_done ##1 !o_done)
    else $error("done not a single pulse after the division");

  AST_DONE_SPACING: assert property (o_done |-> lat_q == DONE_AT)
    else $error("done pulse without a taken request before it");

  AST_SER_FIRST: assert property ($rose(o_ser_valid) |-> o_ser_bit == o_result.code[0])
    else $error("serial output does not start with bit 0");

  AST_SER_LAST: assert property ($fell(o_ser_valid) |->
      $past(ser_seen_q) == acg_pkg::SER_LAST && $past(o_ser_bit) == o_result.code[71])
    else $error("serial output not 72 bits ending with bit 71");

  COV_GENERAL:   cover property (o_done && o_result.general);
  COV_DEDICATED: cover property (o_done && o_result.dedicated);
  COV_PLAIN:     cover property (o_done && !o_result.reserved);
  COV_SERIAL:    cover property ($fell(o_ser_valid));

endmodule
`default_nettype wire

// file: rtl/acg_overlay_gen.sv
// Overlay noise sequence generator: six-stage shift register run once after reset.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module acg_overlay_gen (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // Sequence out, output order kept (bit k is the k-th bit shifted out)
  output logic      [63:0] o_seq,
  output logic             o_ready
);

  acg_pkg::acg_ovl_s s_q;
  acg_pkg::acg_ovl_s s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.ready) begin
      s_d.vec[s_q.cnt] = s_q.win[0];
      // Recurrence of 1+D+D^3+D^4+D^6; bit 63 stays the appended zero
      s_d.win = {s_q.win[0] ^ s_q.win[2] ^ s_q.win[3] ^ s_q.win[5], s_q.win[5:1]};
      if (s_q.cnt == acg_pkg::LFSR_LAST) begin
        s_d.ready = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 6'd1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{win: acg_pkg::LFSR_SEED, vec: '0, cnt: '0, ready: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_seq   = s_q.vec;
  assign o_ready = s_q.ready;

  AST_OVL_VALUE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_q.ready |-> s_q.vec == acg_pkg::OVL_PRINTED)
    else $error("overlay differs from printed sequence");

  AST_OVL_REVERSED: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_q.ready |-> acg_pkg::bit_rev64(s_q.vec) == acg_pkg::LFSR_PRINTED)
    else $error("shift register output differs from printed value");

  AST_OVL_LENGTH: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(s_q.ready) |-> $past(s_q.cnt) == acg_pkg::LFSR_LAST && !s_q.vec[63])
    else $error("overlay not 63 bits plus a zero");

endmodule
`default_nettype wire

// file: sim/acg_link_model.sv
// Link controller model: requests access codes and collects the serial code.
// Assumes it is driven from the bench by hierarchical task calls.
`timescale 1ns/1ps
`default_nettype none
module acg_link_model (
  // Clock
  input  wire logic        i_sys_clk,
  // Answer from the generator
  input  wire logic        i_ready,
  input  wire logic        i_ser_valid,
  input  wire logic        i_ser_bit,
  // Request to the generator
  output logic             o_start,
  output logic [23:0]      o_addr,
  output logic             o_ser_en,
  // Collected serial code
  output logic [71:0]      o_bits,
  output logic [7:0]       o_nbits
);
  initial begin
    o_start  = 1'b0;
    o_addr   = 24'h5A_A5A5;
    o_ser_en = 1'b0;
    o_bits   = '0;
    o_nbits  = 8'h00;
  end

  // Arrival order gives the code position
  always @(posedge i_sys_clk) begin
    if (i_ser_valid === 1'b1) begin
      o_bits[o_nbits] <= i_ser_bit;
      o_nbits         <= o_nbits + 8'h01;
    end
  end

  // Poke keeps start high while busy, which the generator must ignore
  task automatic request(input logic [23:0] a, input logic ser, input logic poke, input int gap);
    int n;
    n = 0;
    // Callers return just after an edge, so no extra offset is added here
    repeat (gap) begin
      @(posedge i_sys_clk);
      #1;
    end
    while (i_ready !== 1'b1 && n < 200) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    o_bits   = '0;
    o_nbits  = 8'h00;
    o_start  = 1'b1;
    o_addr   = a;
    o_ser_en = ser;
    @(posedge i_sys_clk);
    #1;
    // Released lines no longer show the request
    o_start  = poke;
    o_addr   = ~a;
    o_ser_en = ~ser;
    // Short hold only, so the caller still sees the done pulse
    if (poke) begin
      repeat (4) begin
        @(posedge i_sys_clk);
        #1;
        o_addr = o_addr + 24'h00_0001;
      end
      o_start = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: sim/tb_access_code_sync_word_generator.sv
// Self-checking bench for the access code generator with a reference model.
// Assumes the link model file is compiled first and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_access_code_sync_word_generator;
  localparam logic [63:0] OVL   = 64'h3F2A_33DD_69B1_21C1;
  localparam logic [34:0] GPOLY = 35'h5_8571_3DA9;
  localparam logic [23:0] ADDRS [10] = '{24'h00_0000, 24'hFF_FFFF, 24'h9E_8B00, 24'h9E_8B33, 24'h9E_8B3F,
                                         24'h9E_8AFF, 24'h9E_8B40, 24'h80_0000, 24'h7F_FFFF, 24'h9E_8B01};
  logic                 i_sys_clk = 1'b0;
  logic                 i_resetn  = 1'b0;
  logic                 start;
  logic [23:0]          addr;
  logic                 ser_en;
  logic                 ready;
  logic                 done;
  acg_pkg::acg_result_s result;
  logic                 ser_valid;
  logic                 ser_bit;
  logic [71:0]          bits;
  logic [7:0]           nbits;
  int                   bad_count = 0;
  int                   samples_checked = 0;
  int                   seed = 74;
  int                   cyc = 0;
  int                   take_cyc = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  // Taking edge as seen on the pins; a second take moves it
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (ready === 1'b1 && start === 1'b1) begin
      take_cyc <= cyc;
    end
  end

  acg_core dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_start(start), .i_addr(addr),
    .i_ser_en(ser_en), .o_ready(ready), .o_done(done), .o_result(result), .o_ser_valid(ser_valid),
    .o_ser_bit(ser_bit));
  acg_link_model link (.i_sys_clk(i_sys_clk), .i_ready(ready), .i_ser_valid(ser_valid),
    .i_ser_bit(ser_bit), .o_start(start), .o_addr(addr), .o_ser_en(ser_en), .o_bits(bits), .o_nbits(nbits));

  // Plain long division, kept apart from the design's own helpers
  function automatic logic [74:0] model(input logic [23:0] a);
    logic [63:0] p;
    logic [29:0] xt;
    logic [63:0] v;
    logic [63:0] s;
    logic        rsv;
    logic        gen;
    for (int i = 0; i < 64; i++) p[i] = OVL[63-i];
    xt = {(a[23] ? 6'h13 : 6'h2C), a} ^ p[63:34];
    v = {xt, 34'h0_0000_0000};
    for (int i = 63; i >= 34; i--) if (v[i]) v = v ^ ({29'h0, GPOLY} << (i - 34));
    s = {xt, v[33:0]} ^ p;
    rsv = (a >= 24'h9E_8B00) && (a <= 24'h9E_8B3F);
    gen = (a == 24'h9E_8B33);
    return {(a[23] ? 4'h5 : 4'hA), s, (s[0] ? 4'h5 : 4'hA), rsv, gen, rsv & !gen};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic do_reset();
    int n;
    n = 0;
    i_resetn = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    `CMP({ready, done, ser_valid, ser_bit, result}, 79'h0)
    i_resetn = 1'b1;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    `CMP(ready, 1'b1)
  endtask

  task automatic run(input logic [23:0] a, input logic ser, input logic poke, input int gap);
    logic [74:0] e;
    int          n;
    e = model(a);
    n = 0;
    link.request(a, ser, poke, gap);
    while (done !== 1'b1 && n < 100) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    `CMP(result, e)
    `CMP(cyc - take_cyc, 32)
    @(posedge i_sys_clk);
    #1;
    `CMP(done, 1'b0)
    if (ser) begin
      n = 0;
      while (ser_valid === 1'b1 && n < 100) begin
        @(posedge i_sys_clk);
        #1;
        n++;
      end
      `CMP(nbits, 8'h48)
      `CMP(bits, e[74:3])
    end
  endtask

  initial begin
    #(100 * 50000);
    bad_count++;
    finish_test();
  end

  initial begin
    logic [23:0] a;
    do_reset();
    foreach (ADDRS[i]) run(ADDRS[i], i[0], i[1], 0);
    repeat (8) begin
      a = 24'($random(seed));
      run(a, a[5], a[9], int'(a[1:0]));
    end
    // Reset in the middle of a computation, then a fresh request
    link.request(24'h12_3456, 1'b1, 1'b0, 0);
    repeat (10) @(posedge i_sys_clk);
    #1;
    do_reset();
    run(24'h12_3456, 1'b1, 1'b0, 0);
    finish_test();
  end
endmodule
`undef CMP
`default_nettype wire
